// File: core/snu_top.sv
// Shift and normalize unit: variable shift, normalize, round-normalize
// Behaviour
// - Variable shift: positive count shifts right arithmetically, negative rotates left.
// - Count sign is count bit 17.
// - Rotate left re-enters top bits at the bottom in order.
// - Right shift drops low bits and fills top with the sign.
// - Earlier variant: positive count with any of bits 6-10 set yields positive zero.
// - Earlier variant ignores count bits 11 to 16.
// - Later variant: negative count with bits 6-11 not all ones gives negative zero.
// - Later variant: either zero count copies the source, same timing.
// - Later positive count uses low 12 bits; above 60 gives all sign.
// - Later negative count: complement low six bits, modulo 60, rotate left.
// - All-ones and all-zeros sources behave and time like any word.
// - Normalize ops write result word and positive shift count.
// - Shift coefficient up minimally until bit 47 differs from bit 59.
// - Exponent drops by the shift distance.
// - Zero coefficient gives count 48 and positive zero result.
// - Infinite operand: no shift, copy through, count zero.
// - Indefinite operands recognised by top digits, handled like infinite.
// - Earlier variant raises exit flags on special operand; later raises none.
// - Round-normalize appends round bit equal to inverted sign.
// - Round bit moves up with the coefficient into vacated bits.
// - Round-normalize of special operand skips work, copies, clears count.
`timescale 1ns/1ps
`default_nettype none

module snu_top
  import snu_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                later_variant,
  input  wire logic                issue_valid,
  input  wire snu_pkg::snu_req_s   issue,
  output var  snu_pkg::snu_rsp_s   rsp,
  output logic                     done
);

  snu_state_s st_ff;
  snu_state_s nxt_st;

  logic [5:0]        opcode;
  logic [SEL_W-1:0]  res_sel;
  logic [SEL_W-1:0]  cnt_sel;
  logic [SEL_W-1:0]  src_sel;
  logic              cnt_neg;
  logic [SH_W-1:0]   low6;
  logic [SH_W-1:0]   neg_raw;
  logic [SH_W-1:0]   neg_amt;
  logic              early_ovf;
  logic              late_ovf;
  logic              late_zero;
  logic              late_big;
  logic [WORD_W-1:0] shifted;
  logic [WORD_W-1:0] all_sign;
  logic [WORD_W-1:0] norm_word;
  logic [SH_W-1:0]   norm_cnt;
  logic              norm_inf;
  logic              norm_ind;

  assign opcode  = issue.instr[OP_MSB:OP_LSB];
  assign res_sel = issue.instr[RES_SEL_MSB:RES_SEL_LSB];
  assign cnt_sel = issue.instr[CNT_SEL_MSB:CNT_SEL_LSB];
  assign src_sel = issue.instr[SRC_SEL_MSB:SRC_SEL_LSB];

  // Count decode
  assign cnt_neg   = issue.cnt[CNT_SIGN_BIT];
  assign low6      = issue.cnt[SH_W-1:0];
  assign neg_raw   = ~low6;
  assign neg_amt   = (neg_raw >= WRAP_COUNT) ? neg_raw - WRAP_COUNT : neg_raw;
  // Only bits 6-10 are tested, so 11-16 never matter here
  assign early_ovf = !cnt_neg && (issue.cnt[EARLY_TEST_MSB:CNT_TEST_LSB] != '0);
  assign late_ovf  = cnt_neg && (issue.cnt[LATE_TEST_MSB:CNT_TEST_LSB] != LATE_NEG_OK);
  assign late_zero = (issue.cnt == CNT_ZERO_POS) || (issue.cnt == CNT_ZERO_NEG);
  assign late_big  = !cnt_neg && (issue.cnt[LATE_POS_MSB:0] > WORD_BITS12);
  assign all_sign  = {WORD_W{issue.src[WORD_SIGN_BIT]}};

  snu_var_shift #(
    .W      (WORD_W)
  ) u_shift (
    .word   (issue.src),
    .left   (cnt_neg),
    .amt    (cnt_neg ? neg_amt : low6),
    .result (shifted)
  );

  snu_normalize u_norm (
    .word     (issue.src),
    .round_en (opcode == OP_RND_NORM),
    .word_out (norm_word),
    .count    (norm_cnt),
    .is_inf   (norm_inf),
    .is_ind   (norm_ind)
  );

  // Every operation resolves in one pass, so timing never depends on data
  always_comb begin
    nxt_st              = st_ff;
    nxt_st.done         = 1'b0;
    nxt_st.rsp.res_we   = 1'b0;
    nxt_st.rsp.cnt_we   = 1'b0;
    nxt_st.rsp.inf_exit = 1'b0;
    nxt_st.rsp.ind_exit = 1'b0;
    if (issue_valid) begin
      case (opcode)
        OP_VAR_SHIFT: begin
          nxt_st.done        = 1'b1;
          nxt_st.rsp.res_we  = 1'b1;
          nxt_st.rsp.res_sel = res_sel;
          nxt_st.rsp.cnt_sel = cnt_sel;
          nxt_st.rsp.res     = shifted;
          if (!later_variant) begin
            if (early_ovf) begin
              nxt_st.rsp.res = '0;
            end
          end else if (late_zero) begin
            nxt_st.rsp.res = issue.src;
          end else if (late_ovf) begin
            // Negative zero goes back to the source register
            nxt_st.rsp.res     = '1;
            nxt_st.rsp.res_sel = src_sel;
          end else if (late_big) begin
            nxt_st.rsp.res = all_sign;
          end
        end
        OP_NORM,
        OP_RND_NORM: begin
          nxt_st.done        = 1'b1;
          nxt_st.rsp.res_we  = 1'b1;
          nxt_st.rsp.cnt_we  = 1'b1;
          nxt_st.rsp.res_sel = res_sel;
          nxt_st.rsp.cnt_sel = cnt_sel;
          nxt_st.rsp.res     = norm_word;
          nxt_st.rsp.cnt     = {{(CNT_W-SH_W){1'b0}}, norm_cnt};
          nxt_st.rsp.inf_exit = !later_variant && norm_inf;
          nxt_st.rsp.ind_exit = !later_variant && norm_ind;
        end
        default: begin
          nxt_st.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp  = st_ff.rsp;
  assign done = st_ff.done;

endmodule // snu_top

`default_nettype wire

// File: core/snu_pkg.sv
// Shared constants and carrier types for the shift and normalize unit
package snu_pkg;

  localparam int WORD_W  = 60;
  localparam int CNT_W   = 18;
  localparam int INSTR_W = 15;
  localparam int COEF_W  = 48;
  localparam int EXP_W   = 11;
  localparam int SH_W    = 6;
  localparam int SEL_W   = 3;

  // Instruction fields
  localparam int OP_MSB      = 14;
  localparam int OP_LSB      = 9;
  localparam int RES_SEL_MSB = 8;
  localparam int RES_SEL_LSB = 6;
  localparam int CNT_SEL_MSB = 5;
  localparam int CNT_SEL_LSB = 3;
  localparam int SRC_SEL_MSB = 2;
  localparam int SRC_SEL_LSB = 0;

  localparam logic [5:0] OP_VAR_SHIFT = 6'h13;
  localparam logic [5:0] OP_NORM      = 6'h14;
  localparam logic [5:0] OP_RND_NORM  = 6'h15;

  // Count register fields
  localparam int CNT_SIGN_BIT   = 17;
  localparam int CNT_TEST_LSB   = 6;
  localparam int EARLY_TEST_MSB = 10;
  localparam int LATE_TEST_MSB  = 11;
  localparam int LATE_POS_MSB   = 11;

  localparam logic [CNT_W-1:0] CNT_ZERO_POS = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_ZERO_NEG = 18'h3FFFF;
  localparam logic [5:0]       LATE_NEG_OK  = 6'h3F;
  localparam logic [11:0]      WORD_BITS12  = 12'h03C;
  localparam logic [SH_W-1:0]  WRAP_COUNT   = 6'h3C;

  // Word layout
  localparam int WORD_SIGN_BIT = 59;
  localparam int EXP_MSB       = 58;
  localparam int EXP_LSB       = 48;
  localparam int TAG_MSB       = 59;
  localparam int TAG_LSB       = 48;

  localparam logic [11:0] TAG_INF_POS = 12'h7FF;
  localparam logic [11:0] TAG_INF_NEG = 12'h800;
  localparam logic [11:0] TAG_IND_POS = 12'h3FF;
  localparam logic [11:0] TAG_IND_NEG = 12'hC00;

  localparam logic [SH_W-1:0] ZERO_COEF_COUNT = 6'h30;

  typedef struct packed {
    logic [INSTR_W-1:0] instr;
    logic [WORD_W-1:0]  src;
    logic [CNT_W-1:0]   cnt;
  } snu_req_s;

  typedef struct packed {
    logic [WORD_W-1:0] res;
    logic [SEL_W-1:0]  res_sel;
    logic              res_we;
    logic [CNT_W-1:0]  cnt;
    logic [SEL_W-1:0]  cnt_sel;
    logic              cnt_we;
    logic              inf_exit;
    logic              ind_exit;
  } snu_rsp_s;

  typedef struct packed {
    snu_rsp_s rsp;
    logic     done;
  } snu_state_s;

  localparam snu_state_s STATE_RESET = '0;

endpackage

// File: core/snu_var_shift.sv
// Variable shifter: circular left or sign-extending right
`timescale 1ns/1ps
`default_nettype none

module snu_var_shift #(
  parameter int W = 60
) (
  input  wire logic [W-1:0] word,
  input  wire logic         left,
  input  wire logic [5:0]   amt,
  output logic      [W-1:0] result
);

  logic [2*W-1:0] dbl;
  logic [W-1:0]   rot;
  logic [W-1:0]   ars;

  // Caller keeps amt below W for rotates
  assign dbl = {word, word} << amt;
  assign rot = dbl[2*W-1:W];
  // Shifting past the width leaves pure sign copies
  assign ars = W'($signed(word) >>> amt);
  assign result = left ? rot : ars;

endmodule // snu_var_shift

`default_nettype wire

// File: core/snu_normalize.sv
// Normalizer with optional round bit and special-operand bypass
`timescale 1ns/1ps
`default_nettype none

module snu_normalize
  import snu_pkg::*;
(
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              round_en,
  output logic      [WORD_W-1:0] word_out,
  output logic      [SH_W-1:0]   count,
  output logic                   is_inf,
  output logic                   is_ind
);

  logic              sgn;
  logic [WORD_W-1:0] pw;
  logic [COEF_W-1:0] coef;
  logic [COEF_W:0]   ext;
  logic [SH_W-1:0]   lz;
  logic [EXP_W-1:0]  expo;
  logic [11:0]       tag;

  always_comb begin
    tag    = word[TAG_MSB:TAG_LSB];
    is_inf = (tag == TAG_INF_POS) || (tag == TAG_INF_NEG);
    is_ind = (tag == TAG_IND_POS) || (tag == TAG_IND_NEG);
    sgn    = word[WORD_SIGN_BIT];
    // Work on the magnitude; a negative word is the one's complement
    pw     = word ^ {WORD_W{sgn}};
    coef   = pw[COEF_W-1:0];
    lz     = ZERO_COEF_COUNT;
    for (int i = 0; i < COEF_W; i++) begin
      if (coef[i]) begin
        lz = SH_W'(COEF_W - 1 - i);
      end
    end
    // Round bit is the inverted sign, i.e. always one in magnitude form
    ext  = {coef, round_en} << lz;
    expo = pw[EXP_MSB:EXP_LSB] - EXP_W'(lz);
    word_out = {1'b0, expo, ext[COEF_W:1]} ^ {WORD_W{sgn}};
    count    = lz;
    if (coef == '0) begin
      word_out = '0;
      count    = ZERO_COEF_COUNT;
    end
    if (is_inf || is_ind) begin
      word_out = word;
      count    = '0;
    end
  end

endmodule // snu_normalize

`default_nettype wire

// File: tb/snu_top_properties.sv
// Port-level checks for the shift and normalize unit
`timescale 1ns/1ps
`default_nettype none
module snu_top_properties
  import snu_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              later_variant,
  input wire logic              issue_valid,
  input wire snu_pkg::snu_req_s issue,
  input wire snu_pkg::snu_rsp_s rsp,
  input wire logic              done
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [5:0] op;
  logic       vs;
  logic       nm;
  logic       sp;
  logic       ei;
  logic       ej;
  assign op = issue.instr[OP_MSB:OP_LSB];
  assign vs = issue_valid && op == OP_VAR_SHIFT;
  assign nm = issue_valid && (op == OP_NORM || op == OP_RND_NORM);
  assign sp = issue.src[59:48] inside {12'h7FF, 12'h800, 12'h3FF, 12'hC00};
  // Infinite tags differ in their top two bits, indefinite ones agree
  assign ei = !later_variant && (issue.src[59] ^ issue.src[58]);
  assign ej = !later_variant && !(issue.src[59] ^ issue.src[58]);
  property p_done; (vs || nm) |=> done && rsp.res_we; endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_idle; !(vs || nm) |=> !done && !rsp.res_we && !rsp.cnt_we; endproperty
  a_idle: assert property (p_idle) else $error("spurious write");
  property p_cnt; nm |=> rsp.cnt_we && rsp.cnt_sel == $past(issue.instr[5:3]); endproperty
  a_cnt: assert property (p_cnt) else $error("count not written");
  property p_copy; vs && later_variant && (issue.cnt == '0 || issue.cnt == '1) |=> rsp.res == $past(issue.src);
  endproperty
  a_copy: assert property (p_copy) else $error("zero count not copied");
  property p_eovf; vs && !later_variant && !issue.cnt[17] && issue.cnt[10:6] != 5'h00 |=> rsp.res == '0;
  endproperty
  a_eovf: assert property (p_eovf) else $error("early overflow not zero");
  property p_lovf; vs && later_variant && issue.cnt[17] && issue.cnt[11:6] != 6'h3F
    |=> rsp.res == '1 && rsp.res_sel == $past(issue.instr[2:0]); endproperty
  a_lovf: assert property (p_lovf) else $error("late overflow wrong");
  property p_spec; nm && sp |=> rsp.res == $past(issue.src) && rsp.cnt == '0; endproperty
  a_spec: assert property (p_spec) else $error("special not copied");
  property p_flag; nm && sp |=> rsp.inf_exit == $past(ei) && rsp.ind_exit == $past(ej); endproperty
  a_flag: assert property (p_flag) else $error("exit flag wrong");
  property p_zc; nm && !sp && issue.src[47:0] == {48{issue.src[59]}} |=> rsp.res == '0 && rsp.cnt == 18'h00030;
  endproperty
  a_zc: assert property (p_zc) else $error("zero coefficient wrong");
  c_copy: cover property (vs && later_variant && issue.cnt == '1);
  c_lovf: cover property (vs && later_variant && issue.cnt[17] && issue.cnt[11:6] == 6'h00);
  c_spec: cover property (nm && sp && !later_variant);
endmodule // snu_top_properties
bind snu_top snu_top_properties u_props (.clock(clock), .rst(rst), .later_variant(later_variant),
  .issue_valid(issue_valid), .issue(issue), .rsp(rsp), .done(done));
`default_nettype wire

// File: tb/snu_issue_model.sv
// Issue-side model: one request per call, driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module snu_issue_model
  import snu_pkg::*;
(
  input  wire logic              clock,
  output var  logic              issue_valid,
  output var  snu_pkg::snu_req_s issue
);
  initial begin
    issue_valid = 1'b0;
    issue       = '0;
  end
  task automatic send(input snu_req_s r);
    @(negedge clock);
    issue_valid = 1'b1;
    issue       = r;
    @(negedge clock);
    issue_valid = 1'b0;
    // Released fields show garbage so a stale value cannot pass
    issue       = ~r;
  endtask
endmodule // snu_issue_model
`default_nettype wire

// File: tb/snu_top_tb.sv
// Self-checking bench for the shift and normalize unit
`timescale 1ns/1ps
`default_nettype none
module snu_top_tb;
  import snu_pkg::*;
  logic     clock = 1'b0;
  logic     rst = 1'b1;
  logic     later_variant = 1'b0;
  logic     issue_valid;
  snu_req_s issue;
  snu_rsp_s rsp;
  logic     done;
  int       num_errors = 0;
  int       compares = 0;
  always #10 clock = ~clock;
  snu_issue_model pm (.clock(clock), .issue_valid(issue_valid), .issue(issue));
  snu_top dut (.clock(clock), .rst(rst), .later_variant(later_variant), .issue_valid(issue_valid),
    .issue(issue), .rsp(rsp), .done(done));
  task automatic chk_w(input string n, input logic [59:0] e, input logic [59:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_f(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  // Result select 5, count select 3, source select 6
  task automatic run(input logic lv, input logic [5:0] op, input logic [59:0] s, input logic [17:0] c,
                     input logic [59:0] er, input logic [17:0] ec);
    later_variant = lv;
    pm.send({op, 3'h5, 3'h3, 3'h6, s, c});
    chk_f("done", 1'b1, done);
    chk_f("res_we", 1'b1, rsp.res_we);
    chk_w("res", er, rsp.res);
    chk_w("res_sel", (lv && op == OP_VAR_SHIFT && c[17] && c[11:6] != 6'h3F) ? 60'h6 : 60'h5, {57'h0, rsp.res_sel});
    chk_f("cnt_we", op != OP_VAR_SHIFT, rsp.cnt_we);
    if (op != OP_VAR_SHIFT) begin
      chk_w("cnt", {42'h0, ec}, {42'h0, rsp.cnt});
      chk_w("cnt_sel", 60'h3, {57'h0, rsp.cnt_sel});
    end
  endtask
  task automatic t_shift;
    for (int v = 0; v < 2; v++) begin
      run(v[0], OP_VAR_SHIFT, 60'h2D7C000006DB512, 18'h00006, 60'h00B5F000001B6D4, 18'h0);
      run(v[0], OP_VAR_SHIFT, 60'hBE3FD82BFFFFB4D, 18'h0000C, 60'hFFFBE3FD82BFFFF, 18'h0);
      run(v[0], OP_VAR_SHIFT, 60'h4D3D80000000049, 18'h3FFF5, 60'hF60000000012534, 18'h0);
      run(v[0], OP_VAR_SHIFT, 60'h4D3D80000000049, 18'h3FFC0, 60'h69EC0000000024A, 18'h0);
      run(v[0], OP_VAR_SHIFT, 60'hFFFFFFFFFFFFFFF, 18'h00006, 60'hFFFFFFFFFFFFFFF, 18'h0);
      run(v[0], OP_VAR_SHIFT, 60'h000000000000000, 18'h3FFF5, 60'h000000000000000, 18'h0);
    end
    $display("test shift end");
  endtask
  task automatic t_early;
    run(1'b0, OP_VAR_SHIFT, 60'hBE3FD82BFFFFB4D, 18'h00040, 60'h0, 18'h0);
    run(1'b0, OP_VAR_SHIFT, 60'h2D7C000006DB512, 18'h1F806, 60'h00B5F000001B6D4, 18'h0);
    $display("test early end");
  endtask
  task automatic t_late;
    run(1'b1, OP_VAR_SHIFT, 60'hBE3FD82BFFFFB4D, 18'h00000, 60'hBE3FD82BFFFFB4D, 18'h0);
    run(1'b1, OP_VAR_SHIFT, 60'h2D7C000006DB512, 18'h3FFFF, 60'h2D7C000006DB512, 18'h0);
    run(1'b1, OP_VAR_SHIFT, 60'h2D7C000006DB512, 18'h3F03F, 60'hFFFFFFFFFFFFFFF, 18'h0);
    run(1'b1, OP_VAR_SHIFT, 60'hBE3FD82BFFFFB4D, 18'h0003D, 60'hFFFFFFFFFFFFFFF, 18'h0);
    run(1'b1, OP_VAR_SHIFT, 60'h2D7C000006DB512, 18'h00FC1, 60'h0, 18'h0);
    $display("test late end");
  endtask
  task automatic t_norm;
    run(1'b0, OP_NORM, 60'h41C027D400004B2, 18'h0, 60'h4169F5000012C80, 18'h00006);
    run(1'b1, OP_RND_NORM, 60'h41C027D400004B2, 18'h0, 60'h4169F5000012CA0, 18'h00006);
    run(1'b0, OP_RND_NORM, 60'hBE3FD82BFFFFB4D, 18'h0, 60'hBE960AFFFFED35F, 18'h00006);
    run(1'b1, OP_NORM, 60'hE00FFFFFFFFFFFF, 18'h0, 60'h0, 18'h00030);
    $display("test normalize end");
  endtask
  task automatic t_spec;
    logic [11:0] tg [4] = '{12'h7FF, 12'h800, 12'h3FF, 12'hC00};
    logic [59:0] s;
    for (int i = 0; i < 16; i++) begin
      s = {tg[i % 4], 48'h123456789ABC};
      run(i[3], i[2] ? OP_RND_NORM : OP_NORM, s, 18'h3FFFF, s, 18'h0);
      chk_f("inf_exit", !i[3] && !i[1], rsp.inf_exit);
      chk_f("ind_exit", !i[3] && i[1], rsp.ind_exit);
    end
    $display("test special end");
  endtask
  task automatic t_other;
    pm.send({6'h16, 9'h0, 60'h0, 18'h0});
    chk_f("done", 1'b0, done);
    chk_f("res_we", 1'b0, rsp.res_we);
    chk_f("cnt_we", 1'b0, rsp.cnt_we);
    $display("test other opcode end");
  endtask
  task automatic results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Outputs must be clear right after reset, before any request
    chk_f("done_rst", 1'b0, done);
    chk_f("res_we_rst", 1'b0, rsp.res_we);
    chk_w("res_rst", 60'h0, rsp.res);
    t_shift();
    t_early();
    t_late();
    t_norm();
    t_spec();
    t_other();
    results();
  end
endmodule // snu_top_tb
`default_nettype wire
